// ---- bench/pmc_cpu_model.sv ----
module pmc_cpu_model
	import pmc_pkg::*;
(
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// Gate side
	input  wire logic        clr,
	input  wire logic        cpu_clk_en,
	output logic             periph_cycle_en,
	output logic      [15:0] cpu_cnt
);
	timeunit 1ns;
	timeprecision 1ns;
	// Peripheral cycle every system cycle keeps the largest ratio window short
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			periph_cycle_en <= 1'b0;
			cpu_cnt         <= 16'h0000;
		end else begin
			periph_cycle_en <= 1'b1;
			cpu_cnt         <= clr ? 16'h0000 : cpu_cnt + {15'h0000, cpu_clk_en};
		end
	end
endmodule // pmc_cpu_model

// ---- bench/tb_pmc_top.sv ----
module tb_pmc_top;
	timeunit 1ns;
	timeprecision 1ns;
	import pmc_pkg::*;
	logic        pclk = 1'b0, presetn = 1'b0, por_resetn = 1'b0, clr = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, se;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, cpu_clk_en, periph_clk_en, reg_lp, sleeping, pce;
	logic [15:0] cpu_cnt;
	pmc_cpu_ev_s cpu_ev = '0;
	int          err_count = 0, tests_run = 0, cyc = 0;
	always #50 pclk = ~pclk;
	pmc_top i_pmc_top (.pclk(pclk), .presetn(presetn), .por_resetn(por_resetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cpu_ev(cpu_ev), .periph_cycle_en(pce),
		.cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
		.regulator_lowpower_en(reg_lp), .sleeping(sleeping));
	pmc_cpu_model i_pmc_cpu_model (.pclk(pclk), .presetn(presetn), .clr(clr),
		.cpu_clk_en(cpu_clk_en), .periph_cycle_en(pce), .cpu_cnt(cpu_cnt));
	task tally_and_finish();
		$display("mismatches %0d comparisons %0d", err_count, tests_run);
		if (err_count == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Ceiling well above the roughly 4500 cycles the sequence needs
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			tally_and_finish();
		end
	end
	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// Answer is taken at the rising edge that samples pready high, then released
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		rd = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rchk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk("prdata", exp, rd);
	endtask
	task pulse(input logic [4:0] e);
		@(posedge pclk);
		cpu_ev <= pmc_cpu_ev_s'(e);
		@(posedge pclk);
		cpu_ev <= '0;
		@(negedge pclk);
	endtask
	task meas(input int n, input int exp);
		repeat (4) @(posedge pclk);
		clr <= 1'b1;
		@(posedge pclk);
		clr <= 1'b0;
		repeat (n) @(posedge pclk);
		@(negedge pclk);
		chk("cpu_cnt", exp, cpu_cnt);
	endtask
	task t_regs();
		rchk(PMC_OFS_REG_CTRL, 32'h01);
		rchk(PMC_OFS_DOZE_CTRL, 32'h00);
		apb(1'b1, PMC_OFS_REG_CTRL, 32'hFFFFFFFF);
		rchk(PMC_OFS_REG_CTRL, 32'h03);
		apb(1'b1, PMC_OFS_DOZE_CTRL, 32'hFFFFFFFF);
		rchk(PMC_OFS_DOZE_CTRL, 32'hF7);
		apb(1'b0, 12'h008, 32'h0);
		chk("pslverr", 32'h1, {31'h0, se});
		apb(1'b1, PMC_OFS_REG_CTRL, 32'h01);
	endtask
	task t_doze();
		for (int r = 0; r < 8; r++) begin
			apb(1'b1, PMC_OFS_DOZE_CTRL, 32'h40 | r);
			meas(512, 512 >> (r + 1));
		end
		@(posedge pclk);
		cpu_ev.in_circuit_debug_mode <= 1'b1;
		meas(64, 64);
		rchk(PMC_OFS_DOZE_CTRL, 32'h47);
		cpu_ev.in_circuit_debug_mode <= 1'b0;
		apb(1'b1, PMC_OFS_DOZE_CTRL, 32'h07);
		meas(64, 64);
	endtask
	task t_irq();
		apb(1'b1, PMC_OFS_DOZE_CTRL, 32'h60);
		pulse(5'h08);
		rchk(PMC_OFS_DOZE_CTRL, 32'h20);
		apb(1'b1, PMC_OFS_DOZE_CTRL, 32'h40);
		pulse(5'h08);
		rchk(PMC_OFS_DOZE_CTRL, 32'h40);
		apb(1'b1, PMC_OFS_DOZE_CTRL, 32'h10);
		pulse(5'h04);
		rchk(PMC_OFS_DOZE_CTRL, 32'h50);
		apb(1'b1, PMC_OFS_DOZE_CTRL, 32'h00);
		pulse(5'h04);
		rchk(PMC_OFS_DOZE_CTRL, 32'h00);
	endtask
	task t_sleep();
		apb(1'b1, PMC_OFS_DOZE_CTRL, 32'h80);
		apb(1'b1, PMC_OFS_REG_CTRL, 32'h03);
		pulse(5'h10);
		chk("sleeping", 32'h1, {31'h0, sleeping});
		chk("reg_lp", 32'h0, {31'h0, reg_lp});
		meas(16, 0);
		chk("periph_clk_en", 32'h1, {31'h0, periph_clk_en});
		pulse(5'h02);
		@(negedge pclk);
		chk("sleeping", 32'h0, {31'h0, sleeping});
		rchk(PMC_OFS_DOZE_CTRL, 32'h80);
		apb(1'b1, PMC_OFS_DOZE_CTRL, 32'h00);
		pulse(5'h10);
		@(negedge pclk);
		chk("reg_lp", 32'h1, {31'h0, reg_lp});
		chk("periph_clk_en", 32'h0, {31'h0, periph_clk_en});
		pulse(5'h02);
		@(negedge pclk);
		chk("reg_lp", 32'h0, {31'h0, reg_lp});
	endtask
	task t_reset();
		apb(1'b1, PMC_OFS_DOZE_CTRL, 32'hC5);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rchk(PMC_OFS_DOZE_CTRL, 32'h80);
		rchk(PMC_OFS_REG_CTRL, 32'h01);
	endtask
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		por_resetn <= 1'b1;
		t_regs();
		t_doze();
		t_irq();
		t_sleep();
		t_reset();
		tally_and_finish();
	end
endmodule // tb_pmc_top

// ---- shared/pmc_pkg.sv ----
package pmc_pkg;

	// APB byte addresses of the two control registers
	localparam logic [11:0] PMC_OFS_REG_CTRL  = 12'h000;
	localparam logic [11:0] PMC_OFS_DOZE_CTRL = 12'h004;

	// Regulator register fields
	localparam int          PMC_REG_LP_BIT    = 1;
	localparam int          PMC_REG_RSVD_BIT  = 0;
	localparam logic [7:0]  PMC_REG_RST       = 8'h01;

	// Slowdown/idle register fields
	localparam int          PMC_IDLE_BIT      = 7;
	localparam int          PMC_SLOW_BIT      = 6;
	localparam int          PMC_ROI_BIT       = 5;
	localparam int          PMC_DOE_BIT       = 4;
	localparam int          PMC_RATIO_LSB     = 0;
	localparam int          PMC_RATIO_W       = 3;
	localparam logic [7:0]  PMC_DOZE_RST      = 8'h00;
	localparam logic [7:0]  PMC_DOZE_MASK     = 8'hF7;
	localparam logic [7:0]  PMC_REG_MASK      = 8'h03;

	// Doze counter width: ratio 111 needs 256 periph cycles
	localparam int          PMC_CNT_W         = 8;

	// Core power state
	typedef enum logic [2:0] {
		PMC_RUN   = 3'b001,
		PMC_IDLE  = 3'b010,
		PMC_SLEEP = 3'b100
	} pmc_state_e;

	// Events from the CPU/interrupt sequencer
	typedef struct packed {
		logic sleep_instr;
		logic irq_entry;
		logic return_from_interrupt_instr;
		logic wake_irq;
		logic in_circuit_debug_mode;
	} pmc_cpu_ev_s;

endpackage

// ---- verilog/pmc_top.sv ----
// Function
// - Regulator low-power select drives regulator low-current output only in full sleep, not in idle.
// - Regulator bit 0 reads one after reset; software keeps it set.
// - Unimplemented bits read zero and ignore writes.
// - Idle select makes sleep stop CPU clock only; else full sleep.
// - Slowdown active gates CPU cycles by ratio; clear runs full speed.
// - Recover-on-interrupt clears slowdown active at interrupt entry.
// - Slowdown-on-return sets slowdown active on return from interrupt.
// - Ratio field gives 1:2 at 000 doubling up to 1:256 at 111.
// - Debug mode forces full speed without changing stored slowdown bit.
// - Idle select clears only on power-on reset; other bits on every reset.
// - Enabled interrupt ends idle regardless of global enable; idle select kept.
//
// Our own choices: the address map and the APB register port.
module pmc_top
	import pmc_pkg::*;
(
	// Clock and resets
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        por_resetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// CPU and interrupt sequencer
	input  wire pmc_cpu_ev_s cpu_ev,
	input  wire logic        periph_cycle_en,
	output logic             cpu_clk_en,
	output logic             periph_clk_en,
	output logic             regulator_lowpower_en,
	output logic             sleeping
);

	function automatic logic [PMC_CNT_W-1:0] ratio_last(input logic [PMC_RATIO_W-1:0] r);
		ratio_last = PMC_CNT_W'((9'h002 << r) - 9'h001);
	endfunction

	logic             reg_lp_ff, nxt_reg_lp;
	logic             reg_rsvd_ff, nxt_reg_rsvd;
	logic             idle_on_sleep_sel_ff, nxt_idle_on_sleep_sel;
	logic             cpu_slowdown_active_ff, nxt_cpu_slowdown_active;
	logic             full_speed_on_irq_entry_ff, nxt_full_speed_on_irq_entry;
	logic             slowdown_on_irq_return_ff, nxt_slowdown_on_irq_return;
	logic [2:0]       ratio_ff, nxt_ratio;
	logic [31:0]      prdata_ff, nxt_prdata;
	logic             pslverr_ff, nxt_pslverr;
	logic             pready_ff, nxt_pready;
	pmc_state_e       state_ff, nxt_state;
	logic [PMC_CNT_W-1:0] cnt_ff, nxt_cnt;
	logic             cpu_en_ff, nxt_cpu_en;
	logic             per_en_ff, nxt_per_en;
	logic             reg_lpo_ff, nxt_reg_lpo;
	logic             sleeping_ff, nxt_sleeping;

	logic wr_acc;
	logic rd_acc;
	logic hit_reg;
	logic hit_doze;
	logic [7:0] reg_rd;
	logic [7:0] doze_rd;

	assign hit_reg  = (paddr == PMC_OFS_REG_CTRL);
	assign hit_doze = (paddr == PMC_OFS_DOZE_CTRL);
	// Zero-wait slave: access completes on the first penable cycle
	assign wr_acc   = psel & penable & pready_ff & pwrite;
	assign rd_acc   = psel & ~penable & ~pwrite;
	assign reg_rd   = {6'h00, reg_lp_ff, reg_rsvd_ff} & PMC_REG_MASK;
	assign doze_rd  = {idle_on_sleep_sel_ff, cpu_slowdown_active_ff,
		full_speed_on_irq_entry_ff, slowdown_on_irq_return_ff, 1'b0, ratio_ff}
		& PMC_DOZE_MASK;

	// Register file and hardware updates of slowdown bit
	always_comb begin
		nxt_reg_lp                  = reg_lp_ff;
		nxt_reg_rsvd                = reg_rsvd_ff;
		nxt_idle_on_sleep_sel       = idle_on_sleep_sel_ff;
		nxt_cpu_slowdown_active     = cpu_slowdown_active_ff;
		nxt_full_speed_on_irq_entry = full_speed_on_irq_entry_ff;
		nxt_slowdown_on_irq_return  = slowdown_on_irq_return_ff;
		nxt_ratio                   = ratio_ff;
		if (wr_acc && hit_reg) begin
			nxt_reg_lp   = pwdata[PMC_REG_LP_BIT];
			// Software must write one here; a stray zero is still stored and read back
			nxt_reg_rsvd = pwdata[PMC_REG_RSVD_BIT];
		end
		if (wr_acc && hit_doze) begin
			nxt_idle_on_sleep_sel       = pwdata[PMC_IDLE_BIT];
			nxt_cpu_slowdown_active     = pwdata[PMC_SLOW_BIT];
			nxt_full_speed_on_irq_entry = pwdata[PMC_ROI_BIT];
			nxt_slowdown_on_irq_return  = pwdata[PMC_DOE_BIT];
			nxt_ratio = pwdata[PMC_RATIO_LSB +: PMC_RATIO_W];
		end
		// Hardware events win over a simultaneous software write
		if (cpu_ev.irq_entry && full_speed_on_irq_entry_ff) begin
			nxt_cpu_slowdown_active = 1'b0;
		end
		if (cpu_ev.return_from_interrupt_instr && slowdown_on_irq_return_ff) begin
			nxt_cpu_slowdown_active = 1'b1;
		end
	end

	// Idle select survives non-power-on resets
	always_ff @(posedge pclk or negedge por_resetn) begin
		if (!por_resetn) begin
			idle_on_sleep_sel_ff <= 1'b0;
		end else begin
			idle_on_sleep_sel_ff <= nxt_idle_on_sleep_sel;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reg_lp_ff                  <= PMC_REG_RST[PMC_REG_LP_BIT];
			reg_rsvd_ff                <= PMC_REG_RST[PMC_REG_RSVD_BIT];
			cpu_slowdown_active_ff     <= PMC_DOZE_RST[PMC_SLOW_BIT];
			full_speed_on_irq_entry_ff <= PMC_DOZE_RST[PMC_ROI_BIT];
			slowdown_on_irq_return_ff  <= PMC_DOZE_RST[PMC_DOE_BIT];
			ratio_ff                   <= PMC_DOZE_RST[PMC_RATIO_LSB +: PMC_RATIO_W];
		end else begin
			reg_lp_ff                  <= nxt_reg_lp;
			reg_rsvd_ff                <= nxt_reg_rsvd;
			cpu_slowdown_active_ff     <= nxt_cpu_slowdown_active;
			full_speed_on_irq_entry_ff <= nxt_full_speed_on_irq_entry;
			slowdown_on_irq_return_ff  <= nxt_slowdown_on_irq_return;
			ratio_ff                   <= nxt_ratio;
		end
	end

	// APB answer: read data captured in setup, pready high in access
	always_comb begin
		nxt_prdata  = prdata_ff;
		nxt_pslverr = 1'b0;
		nxt_pready  = 1'b1;
		if (rd_acc) begin
			nxt_prdata = hit_reg ? {24'h000000, reg_rd} :
				hit_doze ? {24'h000000, doze_rd} : 32'h00000000;
		end
		if (psel && !penable) begin
			nxt_pslverr = ~(hit_reg | hit_doze);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff  <= 32'h00000000;
			pslverr_ff <= 1'b0;
			pready_ff  <= 1'b0;
		end else begin
			prdata_ff  <= nxt_prdata;
			pslverr_ff <= nxt_pslverr;
			pready_ff  <= nxt_pready;
		end
	end

	// Power state and doze gating
	always_comb begin
		nxt_state   = state_ff;
		nxt_cnt     = cnt_ff;
		nxt_cpu_en  = 1'b0;
		nxt_per_en  = 1'b0;
		nxt_reg_lpo = 1'b0;
		unique case (state_ff)
			PMC_RUN: begin
				if (cpu_ev.sleep_instr && !cpu_ev.wake_irq) begin
					nxt_state = idle_on_sleep_sel_ff ? PMC_IDLE : PMC_SLEEP;
				end
			end
			PMC_IDLE, PMC_SLEEP: begin
				// Wake on any enabled interrupt; global enable not consulted
				if (cpu_ev.wake_irq) begin
					nxt_state = PMC_RUN;
				end
			end
			default: nxt_state = PMC_RUN;
		endcase
		nxt_per_en  = (nxt_state != PMC_SLEEP) & periph_cycle_en;
		nxt_reg_lpo = (nxt_state == PMC_SLEEP) & reg_lp_ff;
		nxt_sleeping = (nxt_state != PMC_RUN);
		if (nxt_state == PMC_RUN) begin
			if (cpu_ev.in_circuit_debug_mode || !nxt_cpu_slowdown_active) begin
				nxt_cpu_en = periph_cycle_en;
				nxt_cnt    = '0;
			end else if (periph_cycle_en) begin
				// One CPU cycle at the end of each ratio period
				nxt_cpu_en = (cnt_ff >= ratio_last(ratio_ff));
				nxt_cnt    = nxt_cpu_en ? '0 : cnt_ff + 1'b1;
			end
		end else begin
			nxt_cnt = '0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff   <= PMC_RUN;
			cnt_ff     <= '0;
			cpu_en_ff  <= 1'b0;
			per_en_ff  <= 1'b0;
			reg_lpo_ff <= 1'b0;
			sleeping_ff <= 1'b0;
		end else begin
			state_ff   <= nxt_state;
			cnt_ff     <= nxt_cnt;
			cpu_en_ff  <= nxt_cpu_en;
			per_en_ff  <= nxt_per_en;
			reg_lpo_ff <= nxt_reg_lpo;
			sleeping_ff <= nxt_sleeping;
		end
	end

	assign prdata                = prdata_ff;
	assign pready                = pready_ff;
	assign pslverr               = pslverr_ff;
	assign cpu_clk_en            = cpu_en_ff;
	assign periph_clk_en         = per_en_ff;
	assign regulator_lowpower_en = reg_lpo_ff;
	assign sleeping              = sleeping_ff;

	property p_roi_clear;
		@(posedge pclk) disable iff (!presetn)
		(cpu_ev.irq_entry && full_speed_on_irq_entry_ff && !cpu_ev.return_from_interrupt_instr)
			|=> !cpu_slowdown_active_ff;
	endproperty
	a_roi_clear: assert property (p_roi_clear) else $error("slowdown not cleared");

	property p_doe_set;
		@(posedge pclk) disable iff (!presetn)
		(cpu_ev.return_from_interrupt_instr && slowdown_on_irq_return_ff) |=> cpu_slowdown_active_ff;
	endproperty
	a_doe_set: assert property (p_doe_set) else $error("slowdown not set");

	property p_unimpl_zero;
		@(posedge pclk) disable iff (!presetn)
		(psel && !penable && !pwrite && hit_doze) |=> (prdata[31:8] == 24'h0 && !prdata[3]);
	endproperty
	a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented bit set");

	property p_idle_keeps;
		@(posedge pclk) disable iff (!presetn)
		(state_ff == PMC_IDLE && cpu_ev.wake_irq && !wr_acc) |=> (state_ff == PMC_RUN)
			&& $stable(idle_on_sleep_sel_ff);
	endproperty
	a_idle_keeps: assert property (p_idle_keeps) else $error("idle exit wrong");

	property p_sleep_sel;
		@(posedge pclk) disable iff (!presetn)
		(state_ff == PMC_RUN && cpu_ev.sleep_instr && !cpu_ev.wake_irq)
			|=> (state_ff == (idle_on_sleep_sel_ff ? PMC_IDLE : PMC_SLEEP));
	endproperty
	a_sleep_sel: assert property (p_sleep_sel) else $error("wrong sleep mode");

	property p_full_speed;
		@(posedge pclk) disable iff (!presetn)
		(nxt_state == PMC_RUN && periph_cycle_en
			&& (cpu_ev.in_circuit_debug_mode || !nxt_cpu_slowdown_active)) |=> cpu_clk_en;
	endproperty
	a_full_speed: assert property (p_full_speed) else $error("cpu not at full speed");

	property p_sleep_gate;
		@(posedge pclk) disable iff (!presetn)
		(state_ff != PMC_RUN) |-> !cpu_clk_en || $past(state_ff) == PMC_RUN;
	endproperty
	a_sleep_gate: assert property (p_sleep_gate) else $error("cpu clocked while asleep");

	property p_reg_lp;
		@(posedge pclk) disable iff (!presetn)
		regulator_lowpower_en |-> reg_lp_ff || $past(reg_lp_ff);
	endproperty
	a_reg_lp: assert property (p_reg_lp) else $error("regulator low power unselected");

	property p_ratio_bound;
		@(posedge pclk) disable iff (!presetn)
		cnt_ff <= ratio_last(ratio_ff) || $changed(ratio_ff);
	endproperty
	a_ratio_bound: assert property (p_ratio_bound) else $error("doze count overrun");

	property p_full_sleep_gate;
		@(posedge pclk) disable iff (!presetn)
		(state_ff == PMC_SLEEP) |-> !periph_clk_en;
	endproperty
	a_full_sleep_gate: assert property (p_full_sleep_gate) else $error("periph clocked in sleep");

	property p_idle_periph;
		@(posedge pclk) disable iff (!presetn)
		(state_ff == PMC_IDLE && $past(periph_cycle_en)) |-> periph_clk_en;
	endproperty
	a_idle_periph: assert property (p_idle_periph) else $error("periph stopped in idle");

	property p_lp_in_sleep;
		@(posedge pclk) disable iff (!presetn)
		(state_ff == PMC_SLEEP && $past(reg_lp_ff)) |-> regulator_lowpower_en;
	endproperty
	a_lp_in_sleep: assert property (p_lp_in_sleep) else $error("regulator not low power");

	property p_doze_hold;
		@(posedge pclk) disable iff (!presetn)
		(nxt_state == PMC_RUN && nxt_cpu_slowdown_active && !cpu_ev.in_circuit_debug_mode
			&& cnt_ff < ratio_last(ratio_ff)) |=> !cpu_clk_en;
	endproperty
	a_doze_hold: assert property (p_doze_hold) else $error("cpu clocked inside doze period");

endmodule // pmc_top
